//--- pkg/fspok_pkg.sv
// package for the fault status and power-ok delay block: command codes,
// bit positions, reset values and the packed carriers shared by the design.
// assumes a pmbus front end outside that decodes frames into command strobes.
//
// What this block does
// - set other-communication-fault on write to read-only command or other comm fault
// - latch over-temperature fault at bit 31, warning at bit 30
// - latch input OV fault 23, OV warn 22, UV warn 21, UV fault 20
// - latch low-vin shutdown 19, input OC fault 18, OC warn 17, OP warn 16
// - latch output OC fault 15, OC warn 13, UC fault 12
// - latch current-share fault at bit 11
// - latch output OV fault 7, OV warn 6, UV warn 5, UV fault 4
// - latch output min/max flag at bit 3, turn-on-time max flag at bit 2
// - phase select FFh or 80h: phase-fault read returns per-phase summary
// - other phase select values: phase-fault read returns selected phase faults
// - summary bit n set when phase n has had a fault
// - off delay field 15:12 gives 2^N+1 switching clocks for N 1..15
// - power-ok drops only after off delay from unmasked event; code 0 one clock
// - on delay field 11:8 gives 2^N+1 switching clocks for N 1..15
// - power-ok releases only after on delay with no unmasked event; code 0 one clock
// - mask bit 0 lets its event pull power-ok low, 1 blocks it
package fspok_pkg;

  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_PHASE        = 8'h04;
  localparam logic [7:0] CMD_STATUS_ALL   = 8'hdb;
  localparam logic [7:0] CMD_PHASE_FAULT  = 8'hdc;
  localparam logic [7:0] CMD_POK_CONFIG   = 8'he3;

  // combined status block bit positions
  localparam int STATUS_ALL_W      = 56;
  localparam int BIT_OTHER_COMM    = 33;
  localparam int BIT_OT_FAULT      = 31;
  localparam int BIT_OT_WARN       = 30;
  localparam int BIT_VIN_OV_FAULT  = 23;
  localparam int BIT_VIN_OV_WARN   = 22;
  localparam int BIT_VIN_UV_WARN   = 21;
  localparam int BIT_VIN_UV_FAULT  = 20;
  localparam int BIT_LOW_VIN       = 19;
  localparam int BIT_IIN_OC_FAULT  = 18;
  localparam int BIT_IIN_OC_WARN   = 17;
  localparam int BIT_PIN_OP_WARN   = 16;
  localparam int BIT_IOUT_OC_FAULT = 15;
  localparam int BIT_IOUT_OC_WARN  = 13;
  localparam int BIT_IOUT_UC_FAULT = 12;
  localparam int BIT_SHARE_FAULT   = 11;
  localparam int BIT_VOUT_OV_FAULT = 7;
  localparam int BIT_VOUT_OV_WARN  = 6;
  localparam int BIT_VOUT_UV_WARN  = 5;
  localparam int BIT_VOUT_UV_FAULT = 4;
  localparam int BIT_VOUT_MINMAX   = 3;
  localparam int BIT_TON_MAX       = 2;

  // power-ok config fields and mask bit positions
  localparam int POK_OFF_DLY_LSB   = 12;
  localparam int POK_ON_DLY_LSB    = 8;
  localparam int POK_DLY_W         = 4;
  localparam int POK_MASK_W        = 8;
  localparam int MASK_VOUT_OV_FAULT = 7;
  localparam int MASK_VOUT_OV_WARN  = 6;
  localparam int MASK_VOUT_UV_FAULT = 5;
  localparam int MASK_VOUT_UV_WARN  = 4;
  localparam int MASK_IOUT_OC_WARN  = 3;
  localparam int MASK_IOUT_OC_FAULT = 2;
  localparam int MASK_VIN_OV_WARN   = 1;
  localparam int MASK_VIN_OV_FAULT  = 0;

  // reset values and phase constants
  localparam logic [15:0] POK_CONFIG_RST    = 16'h0000;
  localparam logic [7:0]  PHASE_RST         = 8'hff;
  localparam logic [7:0]  PHASE_BROADCAST   = 8'hff;
  localparam logic [7:0]  PHASE_ALT_SUMMARY = 8'h80;
  localparam int          NUM_PHASES        = 4;
  localparam int          DLY_CNT_W         = 17;
  localparam int          SYNC_STAGES       = 2;

  // live fault and warning conditions from the sense logic
  typedef struct packed {
    logic ot_fault;
    logic ot_warn;
    logic vin_ov_fault;
    logic vin_ov_warn;
    logic vin_uv_warn;
    logic vin_uv_fault;
    logic low_vin;
    logic iin_oc_fault;
    logic iin_oc_warn;
    logic pin_op_warn;
    logic iout_oc_fault;
    logic iout_oc_warn;
    logic iout_uc_fault;
    logic share_fault;
    logic vout_ov_fault;
    logic vout_ov_warn;
    logic vout_uv_warn;
    logic vout_uv_fault;
    logic vout_minmax;
    logic ton_max;
  } fspok_events_t;

  // one decoded command from the pmbus front end
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } fspok_cmd_t;

endpackage

//--- hdl/fspok_sync.sv
// two-flop synchroniser for a vector of slow pins.
// assumes every bit is an independent level; no word coherence is promised.
`timescale 1ns/1ps
module fspok_sync
  import fspok_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule

//--- hdl/fspok_status_pok.sv
// fault status latches, phase-fault word and power-ok delay timing.
// assumes decoded pmbus commands on the system clock and slow sense pins
// plus the pwm switching clock arriving from outside this clock domain.
`timescale 1ns/1ps
module fspok_status_pok
  import fspok_pkg::*;
(
  input  wire logic                    I_CLK,
  input  wire logic                    I_RST_B,
  input  wire logic                    I_PWM_CLK,
  input  fspok_events_t                I_EVENTS,
  input  wire logic [NUM_PHASES-1:0]   I_PHASE_FAULT,
  input  wire logic [1:0]              I_OWN_PHASE,
  input  wire logic                    I_COMM_FAULT,
  input  fspok_cmd_t                   I_CMD,
  output logic [STATUS_ALL_W-1:0]      O_RDATA,
  output logic                         O_RDATA_VALID,
  output logic                         O_POWER_OK
);

  localparam int EV_W = $bits(fspok_events_t);

  fspok_events_t              ev_sync;
  fspok_events_t              flags_reg;
  logic [NUM_PHASES-1:0]      phase_sync;
  logic [NUM_PHASES-1:0]      phase_flags_reg;
  logic [1:0]                 own_sync;
  logic                       pwm_sync;
  logic                       pwm_prev_reg;
  logic                       pwm_tick;
  logic                       comm_fault_reg;
  logic [15:0]                pok_config_reg;
  logic [7:0]                 phase_reg;
  logic                       clear_faults;
  logic                       bad_write;
  logic                       bad_read;
  logic                       is_write;
  logic                       is_read;
  logic [STATUS_ALL_W-1:0]    status_all;
  logic [15:0]                phase_word;
  logic [POK_MASK_W-1:0]      mask_events;
  logic                       unmasked_bad;
  logic                       mismatch;
  logic [POK_DLY_W-1:0]       dly_code;
  logic [DLY_CNT_W-1:0]       dly_target;
  logic [DLY_CNT_W-1:0]       dly_cnt_reg;
  logic [DLY_CNT_W-1:0]       dly_cnt_next;
  logic                       local_any;
  logic [STATUS_ALL_W-1:0]    rdata_next;

  // event pins in one vector, phase-fault, own-phase and pwm pins in a second; comm fault and commands are not resynchronised
  fspok_sync #(
    .W (EV_W)
  ) u_sync_events (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_async (I_EVENTS),
    .o_sync  (ev_sync)
  );

  fspok_sync #(
    .W (NUM_PHASES + 3)
  ) u_sync_misc (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_async ({I_PHASE_FAULT, I_OWN_PHASE, I_PWM_CLK}),
    .o_sync  ({phase_sync, own_sync, pwm_sync})
  );

  // rising edge of the switching clock becomes a one-cycle tick
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      pwm_prev_reg <= 1'b0;
    end else begin
      pwm_prev_reg <= pwm_sync;
    end
  end

  assign pwm_tick = pwm_sync & ~pwm_prev_reg;

  // command decode
  assign is_write     = I_CMD.valid & I_CMD.write;
  assign is_read      = I_CMD.valid & ~I_CMD.write;
  assign clear_faults = is_write && (I_CMD.code == CMD_CLEAR_FAULTS);

  // writes to read-only codes and unknown codes count as comm faults
  always_comb begin
    bad_write = 1'b0;
    if (is_write) begin
      case (I_CMD.code)
        CMD_CLEAR_FAULTS: bad_write = 1'b0;
        CMD_PHASE:        bad_write = 1'b0;
        CMD_POK_CONFIG:   bad_write = 1'b0;
        CMD_STATUS_ALL:   bad_write = 1'b1;
        CMD_PHASE_FAULT:  bad_write = 1'b1;
        default:          bad_write = 1'b1;
      endcase
    end
  end

  // reads of codes this block does not answer are also comm faults
  always_comb begin
    bad_read = 1'b0;
    if (is_read) begin
      case (I_CMD.code)
        CMD_PHASE:       bad_read = 1'b0;
        CMD_POK_CONFIG:  bad_read = 1'b0;
        CMD_STATUS_ALL:  bad_read = 1'b0;
        CMD_PHASE_FAULT: bad_read = 1'b0;
        default:         bad_read = 1'b1;
      endcase
    end
  end

  // sticky comm fault; a new fault in the clear cycle still lands
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      comm_fault_reg <= 1'b0;
    end else begin
      comm_fault_reg <= (comm_fault_reg & ~clear_faults) | bad_write | bad_read | I_COMM_FAULT;
    end
  end

  // fault and warning latches: set beats clear so no event is lost
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      flags_reg <= '0;
    end else if (clear_faults) begin
      flags_reg <= ev_sync;
    end else begin
      flags_reg <= flags_reg | ev_sync;
    end
  end

  // any local latched flag marks our own phase as faulted
  assign local_any = (|flags_reg) | comm_fault_reg;

  // per-phase fault latches; own slot also picks up local flags
  // local flags about to be cleared must not re-arm the own slot, a fresh
  // event in the clear cycle reaches it one cycle later through flags_reg
  always_ff @(posedge I_CLK) begin
    for (int p = 0; p < NUM_PHASES; p++) begin
      if (!I_RST_B) begin
        phase_flags_reg[p] <= 1'b0;
      end else begin
        phase_flags_reg[p] <= (phase_flags_reg[p] & ~clear_faults) | phase_sync[p] |
                              (local_any && !clear_faults && (own_sync == p[1:0]));
      end
    end
  end

  // software-written configuration
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      pok_config_reg <= POK_CONFIG_RST;
    end else if (is_write && (I_CMD.code == CMD_POK_CONFIG)) begin
      pok_config_reg <= I_CMD.wdata;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      phase_reg <= PHASE_RST;
    end else if (is_write && (I_CMD.code == CMD_PHASE)) begin
      phase_reg <= I_CMD.wdata[7:0];
    end
  end

  // assemble the combined status block from the latches
  always_comb begin
    status_all                    = '0;
    status_all[BIT_OTHER_COMM]    = comm_fault_reg;
    status_all[BIT_OT_FAULT]      = flags_reg.ot_fault;
    status_all[BIT_OT_WARN]       = flags_reg.ot_warn;
    status_all[BIT_VIN_OV_FAULT]  = flags_reg.vin_ov_fault;
    status_all[BIT_VIN_OV_WARN]   = flags_reg.vin_ov_warn;
    status_all[BIT_VIN_UV_WARN]   = flags_reg.vin_uv_warn;
    status_all[BIT_VIN_UV_FAULT]  = flags_reg.vin_uv_fault;
    status_all[BIT_LOW_VIN]       = flags_reg.low_vin;
    status_all[BIT_IIN_OC_FAULT]  = flags_reg.iin_oc_fault;
    status_all[BIT_IIN_OC_WARN]   = flags_reg.iin_oc_warn;
    status_all[BIT_PIN_OP_WARN]   = flags_reg.pin_op_warn;
    status_all[BIT_IOUT_OC_FAULT] = flags_reg.iout_oc_fault;
    status_all[BIT_IOUT_OC_WARN]  = flags_reg.iout_oc_warn;
    status_all[BIT_IOUT_UC_FAULT] = flags_reg.iout_uc_fault;
    status_all[BIT_SHARE_FAULT]   = flags_reg.share_fault;
    status_all[BIT_VOUT_OV_FAULT] = flags_reg.vout_ov_fault;
    status_all[BIT_VOUT_OV_WARN]  = flags_reg.vout_ov_warn;
    status_all[BIT_VOUT_UV_WARN]  = flags_reg.vout_uv_warn;
    status_all[BIT_VOUT_UV_FAULT] = flags_reg.vout_uv_fault;
    status_all[BIT_VOUT_MINMAX]   = flags_reg.vout_minmax;
    status_all[BIT_TON_MAX]       = flags_reg.ton_max;
  end

  // phase-fault word: summary in broadcast modes, else the selected phase
  always_comb begin
    phase_word = '0;
    if ((phase_reg == PHASE_BROADCAST) || (phase_reg == PHASE_ALT_SUMMARY)) begin
      phase_word[NUM_PHASES-1:0] = phase_flags_reg;
    end else if (phase_reg[7:2] != 6'h00) begin
      phase_word = '0; // no such phase in a four-phase stack
    end else if (phase_reg[1:0] == own_sync) begin
      phase_word = status_all[15:0];
    end else begin
      // remote phases only report that they faulted; details live there
      phase_word[0] = phase_flags_reg[phase_reg[1:0]];
    end
  end

  // read mux
  always_comb begin
    rdata_next = '0;
    case (I_CMD.code)
      CMD_STATUS_ALL:  rdata_next = status_all;
      CMD_PHASE_FAULT: rdata_next[15:0] = phase_word;
      CMD_POK_CONFIG:  rdata_next[15:0] = pok_config_reg;
      CMD_PHASE:       rdata_next[7:0] = phase_reg;
      default:         rdata_next = '0;
    endcase
  end

  // read data registered, valid one cycle after the read strobe
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      O_RDATA       <= '0;
      O_RDATA_VALID <= 1'b0;
    end else begin
      O_RDATA_VALID <= is_read;
      if (is_read) begin
        O_RDATA <= rdata_next;
      end
    end
  end

  // live conditions gated by their mask bits; 0 lets the event through
  always_comb begin
    mask_events                     = '0;
    mask_events[MASK_VOUT_OV_FAULT] = ev_sync.vout_ov_fault;
    mask_events[MASK_VOUT_OV_WARN]  = ev_sync.vout_ov_warn;
    mask_events[MASK_VOUT_UV_FAULT] = ev_sync.vout_uv_fault;
    mask_events[MASK_VOUT_UV_WARN]  = ev_sync.vout_uv_warn;
    mask_events[MASK_IOUT_OC_WARN]  = ev_sync.iout_oc_warn;
    mask_events[MASK_IOUT_OC_FAULT] = ev_sync.iout_oc_fault;
    mask_events[MASK_VIN_OV_WARN]   = ev_sync.vin_ov_warn;
    mask_events[MASK_VIN_OV_FAULT]  = ev_sync.vin_ov_fault;
  end

  // live rather than latched, so power-ok can come back once things clear
  assign unmasked_bad = |(mask_events & ~pok_config_reg[POK_MASK_W-1:0]);

  // output disagrees with the condition: a pending transition
  assign mismatch = O_POWER_OK ? unmasked_bad : ~unmasked_bad;

  // delay code follows the direction of the pending change
  assign dly_code = O_POWER_OK ? pok_config_reg[POK_OFF_DLY_LSB +: POK_DLY_W]
                               : pok_config_reg[POK_ON_DLY_LSB +: POK_DLY_W];

  // code 0 is a single clock, else 2^N+1 switching clocks
  always_comb begin
    if (dly_code == '0) begin
      dly_target = DLY_CNT_W'(1);
    end else begin
      dly_target = (DLY_CNT_W'(1) << dly_code) + DLY_CNT_W'(1);
    end
  end

  assign dly_cnt_next = dly_cnt_reg + DLY_CNT_W'(1);

  // delay counter and power-ok; any return to agreement restarts the count
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      dly_cnt_reg <= '0;
      O_POWER_OK  <= 1'b0;
    end else if (!mismatch) begin
      dly_cnt_reg <= '0;
    end else if (pwm_tick) begin
      if (dly_cnt_next >= dly_target) begin
        dly_cnt_reg <= '0;
        O_POWER_OK  <= ~O_POWER_OK;
      end else begin
        dly_cnt_reg <= dly_cnt_next;
      end
    end
  end

endmodule

//--- tb/fspok_host.sv
// host model: issues decoded commands to the block one at a time.
// assumes a command is taken on the first rising edge with valid high.
`timescale 1ns/1ps
module fspok_host
  import fspok_pkg::*;
(
  input  wire logic i_clk,
  output fspok_cmd_t o_cmd
);
  initial o_cmd = '0;

  // one-cycle strobe; released fields flip so stale data is never trusted
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_cmd = '{1'b1, w, c, d};
    @(posedge i_clk);
    #1;
    o_cmd = '{1'b0, ~w, ~c, ~d};
  endtask

  // select a flagged phase, then fetch the block's own full status; the status read ignores the phase
  task automatic detail(input logic [7:0] n);
    send(1'b1, CMD_PHASE, {8'h00, n});
    send(1'b0, CMD_STATUS_ALL, 16'h0000);
  endtask
endmodule

//--- tb/fspok_status_pok_monitor.sv
// checker for the status and power-ok block, bound to its ports.
// assumes two-flop sense synchronisers and registered outputs.
`timescale 1ns/1ps
module fspok_mon
  import fspok_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_PWM_CLK,
  input fspok_events_t I_EVENTS,
  input wire logic [NUM_PHASES-1:0] I_PHASE_FAULT,
  input wire logic [1:0] I_OWN_PHASE,
  input wire logic I_COMM_FAULT,
  input fspok_cmd_t I_CMD,
  input wire logic [STATUS_ALL_W-1:0] O_RDATA,
  input wire logic O_RDATA_VALID,
  input wire logic O_POWER_OK
);
  logic [15:0] cfg_reg;
  logic [7:0] phase_reg;
  fspok_events_t ev1_reg, ev2_reg;
  logic [55:0] h1_reg, h2_reg, h3_reg, h4_reg, steady;
  logic bad;

  function automatic logic [55:0] emap(input fspok_events_t e);
    return {24'h0, e[19:18], 6'h0, e[17:9], 1'b0, e[8:6], 3'h0, e[5:0], 2'h0};
  endfunction

  // shadow of writable settings, same edge as the block
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      cfg_reg <= POK_CONFIG_RST;
      phase_reg <= PHASE_RST;
    end else if (I_CMD.valid && I_CMD.write) begin
      if (I_CMD.code == CMD_POK_CONFIG) cfg_reg <= I_CMD.wdata;
      if (I_CMD.code == CMD_PHASE) phase_reg <= I_CMD.wdata[7:0];
    end
  end

  // event history: ev2 matches what the block's synchroniser presents
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      {ev1_reg, ev2_reg} <= '0;
      {h1_reg, h2_reg, h3_reg, h4_reg} <= '0;
    end else begin
      ev1_reg <= I_EVENTS;
      ev2_reg <= ev1_reg;
      h1_reg <= emap(I_EVENTS);
      h2_reg <= h1_reg;
      h3_reg <= h2_reg;
      h4_reg <= h3_reg;
    end
  end

  // flags held long enough must be latched; unmasked live condition
  assign steady = emap(I_EVENTS) & h1_reg & h2_reg & h3_reg & h4_reg;
  assign bad = |({ev2_reg.vout_ov_fault, ev2_reg.vout_ov_warn, ev2_reg.vout_uv_fault,
                  ev2_reg.vout_uv_warn, ev2_reg.iout_oc_warn, ev2_reg.iout_oc_fault,
                  ev2_reg.vin_ov_warn, ev2_reg.vin_ov_fault} & ~cfg_reg[7:0]);

  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  sequence s_rd(c);
    I_CMD.valid && !I_CMD.write && I_CMD.code == c;
  endsequence
  sequence s_bad_wr;
    I_CMD.valid && I_CMD.write && (I_CMD.code == CMD_PHASE_FAULT || I_CMD.code == CMD_STATUS_ALL);
  endsequence

  property p_rd_ans;
    I_CMD.valid && !I_CMD.write |=> O_RDATA_VALID;
  endproperty
  property p_rd_only;
    O_RDATA_VALID |-> $past(I_CMD.valid && !I_CMD.write);
  endproperty
  property p_ro_wr;
    s_bad_wr ##1 !I_CMD.valid ##1 s_rd(CMD_STATUS_ALL) |=> O_RDATA[BIT_OTHER_COMM];
  endproperty
  property p_latch;
    s_rd(CMD_STATUS_ALL) |=> (O_RDATA & $past(steady)) == $past(steady);
  endproperty
  property p_cfg_rb;
    s_rd(CMD_POK_CONFIG) |=> O_RDATA[15:0] == cfg_reg;
  endproperty
  property p_sum;
    s_rd(CMD_PHASE_FAULT) ##0 (phase_reg == PHASE_BROADCAST || phase_reg == PHASE_ALT_SUMMARY)
      |=> O_RDATA[55:4] == '0;
  endproperty
  // the block decided one edge before the change became visible
  property p_pok_on;
    $rose(O_POWER_OK) |-> $past(!bad);
  endproperty
  property p_pok_off;
    $fell(O_POWER_OK) |-> $past(bad);
  endproperty

  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  a_rd_only: assert property (p_rd_only) else $error("answer without read");
  a_ro_wr: assert property (p_ro_wr) else $error("read-only write not flagged");
  a_latch: assert property (p_latch) else $error("flag not latched");
  a_cfg_rb: assert property (p_cfg_rb) else $error("config readback wrong");
  a_sum: assert property (p_sum) else $error("summary upper bits set");
  a_pok_on: assert property (p_pok_on) else $error("power-ok rose with event");
  a_pok_off: assert property (p_pok_off) else $error("power-ok fell without event");
endmodule

bind fspok_status_pok fspok_mon u_mon (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PWM_CLK(I_PWM_CLK),
  .I_EVENTS(I_EVENTS), .I_PHASE_FAULT(I_PHASE_FAULT), .I_OWN_PHASE(I_OWN_PHASE),
  .I_COMM_FAULT(I_COMM_FAULT), .I_CMD(I_CMD), .O_RDATA(O_RDATA),
  .O_RDATA_VALID(O_RDATA_VALID), .O_POWER_OK(O_POWER_OK));

//--- tb/tb.sv
// testbench: host model drives commands, read answers checked from a queue,
// power-ok delays measured in pwm periods of an 80 ns free-running clock.
`timescale 1ns/1ps
module tb;
  import fspok_pkg::*;
  typedef struct packed {logic [55:0] val; logic [55:0] msk;} fspok_exp_t;
  logic clk, rst_b, pwm, cf, rdv, pok;
  fspok_events_t ev;
  logic [3:0] pf;
  logic [1:0] own;
  fspok_cmd_t cmd;
  logic [55:0] rdata, acc;
  logic [31:0] r;
  fspok_exp_t q[$];
  fspok_exp_t x;
  int error_cnt = 0;
  int checks = 0;
  int pwm_n = 0;
  int cyc = 0;
  int t;
  int mev[8] = '{17, 16, 9, 8, 3, 2, 4, 5};

  fspok_status_pok uut (.I_CLK(clk), .I_RST_B(rst_b), .I_PWM_CLK(pwm), .I_EVENTS(ev),
    .I_PHASE_FAULT(pf), .I_OWN_PHASE(own), .I_COMM_FAULT(cf), .I_CMD(cmd),
    .O_RDATA(rdata), .O_RDATA_VALID(rdv), .O_POWER_OK(pok));
  fspok_host u_host (.i_clk(clk), .o_cmd(cmd));

  function automatic logic [55:0] emap(input fspok_events_t e);
    return {24'h0, e[19:18], 6'h0, e[17:9], 1'b0, e[8:6], 3'h0, e[5:0], 2'h0};
  endfunction

  task automatic chk(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  task automatic rd(input logic [7:0] c, input logic [55:0] v, input logic [55:0] m);
    q.push_back(fspok_exp_t'{v, m});
    u_host.send(1'b0, c, 16'h0000);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one pwm edge of slack covers the synchroniser latency
  task automatic meas(input logic lvl, input int n);
    int n0, k;
    n0 = pwm_n;
    k = 0;
    while (pok !== lvl && k < 5000) begin
      @(negedge clk);
      k++;
    end
    chk(pok === lvl && (pwm_n - n0 == n || pwm_n - n0 == n + 1), "power-ok delay wrong");
  endtask

  task automatic hold(input logic lvl, input int n);
    repeat (n) begin
      @(posedge pwm);
      chk(pok === lvl, "power-ok moved");
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // pwm switching clock, unrelated in phase to the system clock
  initial begin
    pwm = 1'b0;
    #3;
    forever #40 pwm = ~pwm;
  end
  always @(posedge pwm) pwm_n++;

  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // pair each read answer with the oldest note
  always @(negedge clk) if (rdv === 1'b1) begin
    if (q.size() == 0) chk(1'b0, "unexpected read answer");
    else begin
      x = q.pop_front();
      chk((rdata & x.msk) === x.val, "read data mismatch");
    end
  end

  initial begin
    {rst_b, cf, ev, pf} = '0;
    own = 2'd2;
    void'($urandom(32'h1039d693));
    tick(10);
    rst_b = 1'b1;
    meas(1'b1, 1);
    rd(CMD_POK_CONFIG, 56'h0, 56'hffff);
    rd(CMD_PHASE, 56'hff, 56'hff);
    rd(CMD_STATUS_ALL, 56'h0, '1);
    // delay codes 0 through 6, off and on alike
    for (int c = 0; c < 7; c++) begin
      u_host.send(1'b1, CMD_POK_CONFIG, {c[3:0], c[3:0], 8'h00});
      rd(CMD_POK_CONFIG, {40'h0, c[3:0], c[3:0], 8'h00}, 56'hffff);
      t = (c == 0) ? 1 : (1 << c) + 1;
      ev.vout_ov_fault = 1'b1;
      meas(1'b0, t);
      tick(1);
      ev.vout_ov_fault = 1'b0;
      meas(1'b1, t);
    end
    // blips shorter than the off delay must never reach the pin
    u_host.send(1'b1, CMD_POK_CONFIG, 16'h2200);
    repeat (3) begin
      ev.vout_uv_warn = 1'b1;
      hold(1'b1, 3);
      tick(1);
      ev.vout_uv_warn = 1'b0;
      hold(1'b1, 1);
      tick(1);
    end
    for (int i = 0; i < 8; i++) begin
      u_host.send(1'b1, CMD_POK_CONFIG, 16'h00ff);
      ev[mev[i]] = 1'b1;
      hold(1'b1, 4);
      // unmask with the event gone so the delay starts from a driven edge
      tick(1);
      ev = '0;
      u_host.send(1'b1, CMD_POK_CONFIG, {8'h00, ~(8'h01 << i)});
      ev[mev[i]] = 1'b1;
      meas(1'b0, 1);
      tick(1);
      ev = '0;
      meas(1'b1, 1);
    end
    // random flags accumulate and survive until cleared
    acc = '0;
    u_host.send(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    repeat (4) begin
      r = $urandom;
      ev = r[19:0];
      acc = acc | emap(ev);
      tick(6);
      rd(CMD_STATUS_ALL, acc, '1);
      ev = '0;
      tick(4);
      rd(CMD_STATUS_ALL, acc, '1);
    end
    u_host.send(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    rd(CMD_STATUS_ALL, 56'h0, '1);
    u_host.send(1'b1, CMD_PHASE_FAULT, 16'h0000);
    rd(CMD_STATUS_ALL, 56'h1 << BIT_OTHER_COMM, '1);
    u_host.send(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    cf = 1'b1;
    tick(1);
    cf = 1'b0;
    rd(CMD_STATUS_ALL, 56'h1 << BIT_OTHER_COMM, '1);
    // phase word: summary, own phase detail, other phases
    u_host.send(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    pf = 4'h8;
    tick(4);
    rd(CMD_PHASE_FAULT, 56'h8, '1);
    u_host.send(1'b1, CMD_PHASE, 16'h0080);
    ev.vout_ov_fault = 1'b1;
    tick(6);
    ev = '0;
    rd(CMD_PHASE_FAULT, 56'hc, '1);
    q.push_back(fspok_exp_t'{56'h80, '1});
    u_host.detail(8'h02);
    rd(CMD_PHASE_FAULT, 56'h80, '1);
    u_host.send(1'b1, CMD_PHASE, 16'h0003);
    rd(CMD_PHASE_FAULT, 56'h1, '1);
    u_host.send(1'b1, CMD_PHASE, 16'h0001);
    rd(CMD_PHASE_FAULT, 56'h0, '1);
    tick(4);
    chk(q.size() == 0, "read answer missing");
    finish_test();
  end
endmodule
